// [logic/servo_diag_defines.svh]
// offsets, codes, reset values and limits of the diagnostic parameter bank
`ifndef SERVO_DIAG_DEFINES_SVH
`define SERVO_DIAG_DEFINES_SVH
`define ADDR_JOG 16'h040A
`define ADDR_FORCE 16'h040C
`define ADDR_INSTAT 16'h040E
`define ADDR_KEYPAD 16'h0410
`define ADDR_OUTSTAT 16'h0412
`define ADDR_ADJ 16'h0414
`define ADDR_SPD1 16'h0416
`define ADDR_SPD2 16'h0418
`define ADDR_TRQ1 16'h041A
`define ADDR_TRQ2 16'h041A
`define JOG_MAX 16'h1388
`define JOG_CODE_POS 16'h1386
`define JOG_CODE_NEG 16'h1387
`define JOG_CODE_STOP 16'h0000
`define JOG_SPEED_RST 16'h0014
`define FORCE_RST 16'h0000
`define SDI_RST 9'h000
`define ADJ_RST 16'h0000
`define ADJ_MAX 16'h0006
`define ADJ_ALL 16'h0005
`define TRIM_RST 16'h0000
`define TRIM_MAX 16'h7FFF
`define PCTRL_RESTORE 16'h000A
`define PCTRL_ADJ 16'h0014
`define PCTRL_TRIM 16'h0016
`define FORCE_FUNC_HI 4'h3
`define NUM_DI 9
`define NUM_DO 5
`define NUM_KEYS 5
`endif

// [logic/servo_diag_pkg.sv]
// types shared by the diagnostic parameter bank
`default_nettype none
package servo_diag_pkg;
  typedef enum logic [3:0] {
    SEL_NONE, SEL_JOG, SEL_FORCE, SEL_INSTAT, SEL_KEYPAD, SEL_OUTSTAT,
    SEL_ADJ, SEL_SPD1, SEL_SPD2, SEL_TRQ
  } reg_sel_t;
endpackage
`default_nettype wire

// [logic/param_req_if.sv]
// decoded parameter request passed from the request stage to the bank
`timescale 1ns/1ps
`default_nettype none
interface param_req_if;
  import servo_diag_pkg::*;
  reg_sel_t sel;
  logic wr;
  logic rd;
  logic [15:0] wdata;
  modport stage (output sel, output wr, output rd, output wdata);
  modport bank (input sel, input wr, input rd, input wdata);
endinterface
`default_nettype wire

// [logic/param_req_stage.sv]
// registers a parameter access and decodes its address
`timescale 1ns/1ps
`default_nettype none
`include "servo_diag_defines.svh"
module param_req_stage
  import servo_diag_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw access
  input wire logic [15:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] wdata,
  // decoded access
  param_req_if.stage req
);
  reg_sel_t next_sel;

  // odd halves of each pair decode to nothing and so read zero
  always_comb
  begin
    if (addr == `ADDR_JOG) next_sel = SEL_JOG;
    else if (addr == `ADDR_FORCE) next_sel = SEL_FORCE;
    else if (addr == `ADDR_INSTAT) next_sel = SEL_INSTAT;
    else if (addr == `ADDR_KEYPAD) next_sel = SEL_KEYPAD;
    else if (addr == `ADDR_OUTSTAT) next_sel = SEL_OUTSTAT;
    else if (addr == `ADDR_ADJ) next_sel = SEL_ADJ;
    else if (addr == `ADDR_SPD1) next_sel = SEL_SPD1;
    else if (addr == `ADDR_SPD2) next_sel = SEL_SPD2;
    else if (addr == `ADDR_TRQ1) next_sel = SEL_TRQ;
    else next_sel = SEL_NONE;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req.sel <= SEL_NONE;
      req.wr <= 1'b0;
      req.rd <= 1'b0;
      req.wdata <= 16'h0000;
    end
    else
    begin
      req.sel <= next_sel;
      req.wr <= wr_en;
      req.rd <= rd_en;
      req.wdata <= wdata;
    end
  end

  chk_odd_addr_none: assert property (@(posedge clk) disable iff (!rst_n)
    addr[0] |=> req.sel == SEL_NONE)
    else $error("odd link address decoded to a register");
endmodule
`default_nettype wire

// [logic/do_select.sv]
// picks the state of one digital output
`timescale 1ns/1ps
`default_nettype none
`include "servo_diag_defines.svh"
module do_select #(
  parameter int IDX = 0
) (
  // selection inputs
  input wire logic [7:0] func_code,
  input wire logic native,
  input wire logic [15:0] forced_word,
  input wire logic force_mode,
  // result
  output logic value
);
  always_comb
  begin
    if (force_mode)
      value = forced_word[IDX];
    else if (func_code[7:4] == `FORCE_FUNC_HI)
      value = forced_word[func_code[3:0]];
    else
      value = native;
  end
endmodule
`default_nettype wire

// [logic/servo_diag_param_bank.sv]
// diagnostic parameter bank of the servo drive
`timescale 1ns/1ps
`default_nettype none
`include "servo_diag_defines.svh"
module servo_diag_param_bank
  import servo_diag_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // parameter access, shared by keypad and link
  input wire logic [15:0] ADDR,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [15:0] WDATA,
  output logic [15:0] RDATA,
  output logic RVALID,
  // drive settings
  input wire logic [15:0] PARAM_CTRL,
  input wire logic [8:0] INPUT_SRC_SEL,
  input wire logic [39:0] OUT_FUNC_ASSIGN,
  input wire logic FORCE_MODE,
  // terminals and keys
  input wire logic [8:0] EXT_DI,
  input wire logic [4:0] DO_NATIVE,
  input wire logic [4:0] KEY_PRESSED,
  // jog
  output logic [15:0] JOG_SPEED,
  output logic JOG_POS,
  output logic JOG_NEG,
  // resolved inputs and outputs
  output logic [8:0] DI_FINAL,
  output logic [4:0] DO_STATE,
  // adjustment
  output logic ADJ_START,
  output logic [4:0] ADJ_RUN,
  output logic [15:0] SPEED_TRIM_ONE,
  output logic [15:0] SPEED_TRIM_TWO,
  output logic [15:0] TORQUE_TRIM_ONE,
  output logic [15:0] TORQUE_TRIM_TWO
);
  param_req_if req ();
  logic [15:0] jog_command;
  logic [15:0] forced_output_word;
  logic [8:0] software_inputs;
  logic [15:0] adjustment_selector;
  logic [8:0] next_di;
  logic [4:0] next_do;
  logic pctrl_is_restore;
  logic pctrl_was_restore;
  logic restore;
  logic wr_jog;
  logic wr_adj;
  logic trim_ok;
  reg_sel_t rd_sel;
  // ********************************
  // request stage and output select
  // ********************************
  param_req_stage u_stage (
    .clk(CLK),
    .rst_n(RST_N),
    .addr(ADDR),
    .wr_en(WR_EN),
    .rd_en(RD_EN),
    .wdata(WDATA),
    .req(req)
  );
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_DO; gi++)
    begin : g_do
      do_select #(.IDX(gi)) u_sel (
        .func_code(OUT_FUNC_ASSIGN[gi*8 +: 8]),
        .native(DO_NATIVE[gi]),
        .forced_word(forced_output_word),
        .force_mode(FORCE_MODE),
        .value(next_do[gi])
      );
    end
  endgenerate
  // one request port serves both keypad and link, so they cannot differ
  assign next_di = (INPUT_SRC_SEL & software_inputs) | (~INPUT_SRC_SEL & EXT_DI);
  assign wr_jog = req.wr && (req.sel == SEL_JOG);
  assign wr_adj = req.wr && (req.sel == SEL_ADJ) && (PARAM_CTRL == `PCTRL_ADJ);
  assign trim_ok = (PARAM_CTRL == `PCTRL_TRIM) && (req.wdata <= `TRIM_MAX);
  assign restore = pctrl_is_restore && !pctrl_was_restore;
  // ********************************
  // restore-defaults detect
  // ********************************
  // acts once on entry, so a held setting does not pin registers at default
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pctrl_is_restore <= 1'b0;
      pctrl_was_restore <= 1'b0;
    end
    else
    begin
      pctrl_is_restore <= (PARAM_CTRL == `PCTRL_RESTORE);
      pctrl_was_restore <= pctrl_is_restore;
    end
  end
  // ********************************
  // jog
  // ********************************
  // direction codes lie inside the speed range and win over it
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      jog_command <= `JOG_SPEED_RST;
      JOG_SPEED <= `JOG_SPEED_RST;
      JOG_POS <= 1'b0;
      JOG_NEG <= 1'b0;
    end
    else if (restore)
    begin
      jog_command <= `JOG_SPEED_RST;
      JOG_SPEED <= `JOG_SPEED_RST;
      JOG_POS <= 1'b0;
      JOG_NEG <= 1'b0;
    end
    else if (wr_jog && req.wdata <= `JOG_MAX)
    begin
      jog_command <= req.wdata;
      if (req.wdata == `JOG_CODE_STOP)
      begin
        JOG_POS <= 1'b0;
        JOG_NEG <= 1'b0;
      end
      else if (req.wdata == `JOG_CODE_POS)
      begin
        JOG_POS <= 1'b1;
        JOG_NEG <= 1'b0;
      end
      else if (req.wdata == `JOG_CODE_NEG)
      begin
        JOG_POS <= 1'b0;
        JOG_NEG <= 1'b1;
      end
      else
        JOG_SPEED <= req.wdata;
    end
  end
  // ********************************
  // forced outputs and software inputs
  // ********************************
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      forced_output_word <= `FORCE_RST;
    else if (restore)
      forced_output_word <= `FORCE_RST;
    else if (req.wr && req.sel == SEL_FORCE)
      forced_output_word <= req.wdata;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      software_inputs <= `SDI_RST;
    else if (restore)
      software_inputs <= `SDI_RST;
    else if (req.wr && req.sel == SEL_INSTAT)
      software_inputs <= req.wdata[8:0];
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      DI_FINAL <= 9'h000;
      DO_STATE <= 5'h00;
    end
    else
    begin
      DI_FINAL <= next_di;
      DO_STATE <= next_do;
    end
  end
  // ********************************
  // adjustment selector
  // ********************************
  // out-of-range codes and writes outside setting 20 are dropped whole
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      adjustment_selector <= `ADJ_RST;
      ADJ_START <= 1'b0;
      ADJ_RUN <= 5'h00;
    end
    else if (restore)
    begin
      adjustment_selector <= `ADJ_RST;
      ADJ_START <= 1'b0;
    end
    else if (wr_adj && req.wdata <= `ADJ_MAX)
    begin
      adjustment_selector <= req.wdata;
      ADJ_START <= (req.wdata != `ADJ_RST);
      case (req.wdata[2:0])
        3'h1: ADJ_RUN <= 5'h01;
        3'h2: ADJ_RUN <= 5'h02;
        3'h3: ADJ_RUN <= 5'h04;
        3'h4: ADJ_RUN <= 5'h08;
        3'h5: ADJ_RUN <= 5'h0F;
        3'h6: ADJ_RUN <= 5'h10;
        default: ADJ_RUN <= 5'h00;
      endcase
    end
    else
      ADJ_START <= 1'b0;
  end
  // ********************************
  // drift trims
  // ********************************
  // no restore term here: defaults must never wipe factory trims
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      SPEED_TRIM_ONE <= `TRIM_RST;
      SPEED_TRIM_TWO <= `TRIM_RST;
      TORQUE_TRIM_ONE <= `TRIM_RST;
      TORQUE_TRIM_TWO <= `TRIM_RST;
    end
    else if (req.wr && trim_ok)
    begin
      if (req.sel == SEL_SPD1) SPEED_TRIM_ONE <= req.wdata;
      if (req.sel == SEL_SPD2) SPEED_TRIM_TWO <= req.wdata;
      if (req.sel == SEL_TRQ) TORQUE_TRIM_ONE <= req.wdata;
      if (req.sel == SEL_TRQ) TORQUE_TRIM_TWO <= req.wdata;
    end
  end
  // ********************************
  // read path
  // ********************************
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      RDATA <= 16'h0000;
      RVALID <= 1'b0;
      rd_sel <= SEL_NONE;
    end
    else
    begin
      RVALID <= req.rd;
      rd_sel <= req.sel;
      if (!req.rd) RDATA <= 16'h0000;
      else if (req.sel == SEL_JOG) RDATA <= jog_command;
      else if (req.sel == SEL_FORCE) RDATA <= forced_output_word;
      else if (req.sel == SEL_INSTAT) RDATA <= {7'h00, next_di};
      else if (req.sel == SEL_KEYPAD) RDATA <= {11'h000, KEY_PRESSED};
      else if (req.sel == SEL_OUTSTAT) RDATA <= {11'h000, next_do};
      else if (req.sel == SEL_ADJ) RDATA <= adjustment_selector;
      else if (req.sel == SEL_SPD1) RDATA <= SPEED_TRIM_ONE;
      else if (req.sel == SEL_SPD2) RDATA <= SPEED_TRIM_TWO;
      else if (req.sel == SEL_TRQ) RDATA <= TORQUE_TRIM_ONE;
      else RDATA <= 16'h0000;
    end
  end
  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_speed_write;
    wr_jog && !restore && req.wdata != `JOG_CODE_STOP && req.wdata <= `JOG_MAX
      && req.wdata != `JOG_CODE_POS && req.wdata != `JOG_CODE_NEG;
  endsequence
  sequence s_adj_all_write;
    wr_adj && !restore && req.wdata == `ADJ_ALL;
  endsequence

  chk_jog_speed_take: assert property (s_speed_write |=> JOG_SPEED == $past(req.wdata))
    else $error("jog speed not taken");
  chk_jog_pos_dir: assert property (wr_jog && !restore && req.wdata == `JOG_CODE_POS
    |=> JOG_POS && !JOG_NEG)
    else $error("positive jog not started");
  chk_jog_neg_dir: assert property (wr_jog && !restore && req.wdata == `JOG_CODE_NEG
    |=> !JOG_POS && JOG_NEG)
    else $error("negative jog not started");
  chk_jog_stop_hold: assert property (wr_jog && req.wdata == `JOG_CODE_STOP
    |=> !JOG_POS && !JOG_NEG)
    else $error("jog not stopped");
  chk_force_direct: assert property (FORCE_MODE |=> DO_STATE == $past(forced_output_word[4:0]))
    else $error("forced outputs not applied");
  chk_force_func: assert property (!FORCE_MODE && OUT_FUNC_ASSIGN[7:4] == `FORCE_FUNC_HI
    |=> DO_STATE[0] == $past(forced_output_word[OUT_FUNC_ASSIGN[3:0]]))
    else $error("output function 0x3n not followed");
  chk_instat_read: assert property (RVALID && rd_sel == SEL_INSTAT
    |-> RDATA == {7'h00, DI_FINAL})
    else $error("input status read differs from final inputs");
  chk_sdi_write: assert property (req.wr && req.sel == SEL_INSTAT && !restore
    ##1 INPUT_SRC_SEL == 9'h1FF |=> DI_FINAL == $past(software_inputs))
    else $error("software inputs not used");
  chk_keypad_read: assert property (RVALID && rd_sel == SEL_KEYPAD
    |-> RDATA == {11'h000, $past(KEY_PRESSED)})
    else $error("keypad read wrong");
  chk_adj_all_run: assert property (s_adj_all_write |=> ADJ_START && ADJ_RUN == 5'h0F ##1 !ADJ_START)
    else $error("code 5 did not run four adjustments");
  chk_adj_gate: assert property (ADJ_START |-> $past(PARAM_CTRL) == `PCTRL_ADJ)
    else $error("adjustment started without setting 20");
  chk_trim_lock: assert property (PARAM_CTRL != `PCTRL_TRIM |=> $stable(SPEED_TRIM_ONE))
    else $error("trim changed while locked");
  chk_trim_restore: assert property (restore && !(req.wr && trim_ok)
    |=> $stable(TORQUE_TRIM_TWO))
    else $error("restore changed a trim");
endmodule
`default_nettype wire

// [bench/host_link_model.sv]
// host side of the parameter link: single reads and writes
`timescale 1ns/1ps
`default_nettype none
module host_link_model
(
  // clock
  input wire logic clk,
  // access port of the bank
  output logic [15:0] addr,
  output logic wr_en,
  output logic rd_en,
  output logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic rvalid
);
  // storage mode assumed at 5 before any jog traffic
  // no servo-on command is ever sent, so adjustments run with servo off
  initial
  begin
    addr = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wdata = 16'h0000;
  end
  // released lines show the inverse, never a stale copy
  task automatic write_word(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  task automatic read_word(input logic [15:0] a, output logic [15:0] d, output bit ok);
    int n;
    @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    addr = ~a;
    ok = 1'b0;
    d = 16'h0000;
    for (n = 0; n < 4 && !ok; n++)
    begin
      if (rvalid === 1'b1)
      begin
        ok = 1'b1;
        d = rdata;
      end
      else
        @(negedge clk);
    end
  endtask
endmodule
`default_nettype wire

// [bench/servo_diag_param_bank_bench.sv]
// self-checking bench of the diagnostic parameter bank
`timescale 1ns/1ps
`default_nettype none
`include "servo_diag_defines.svh"
module servo_diag_param_bank_bench;
  logic CLK = 1'b0;
  logic RST_N, WR_EN, RD_EN, RVALID, FORCE_MODE, JOG_POS, JOG_NEG, ADJ_START;
  logic [15:0] ADDR, WDATA, RDATA, PARAM_CTRL, JOG_SPEED;
  logic [15:0] SPEED_TRIM_ONE, SPEED_TRIM_TWO, TORQUE_TRIM_ONE, TORQUE_TRIM_TWO;
  logic [8:0] INPUT_SRC_SEL, EXT_DI, DI_FINAL;
  logic [39:0] OUT_FUNC_ASSIGN;
  logic [4:0] DO_NATIVE, KEY_PRESSED, DO_STATE, ADJ_RUN;
  int num_errors, total_checks, seed, i, n;
  int m_jog, m_spd, m_pos, m_neg, m_force, m_sdi, m_adj, m_run;
  int m_trim[4];
  logic [15:0] rd;
  bit ok;
  servo_diag_param_bank servo_diag_param_bank_i (.*);
  host_link_model host_link_model_i (.clk(CLK), .addr(ADDR), .wr_en(WR_EN), .rd_en(RD_EN),
    .wdata(WDATA), .rdata(RDATA), .rvalid(RVALID));
  always #50 CLK = ~CLK;
  // ********************
  // model and checks
  // ********************
  function automatic logic [4:0] exp_do();
    logic [4:0] v;
    logic [7:0] c;
    for (int k = 0; k < 5; k++)
    begin
      c = OUT_FUNC_ASSIGN[8*k+:8];
      if (FORCE_MODE) v[k] = m_force[k];
      else if (c[7:4] == 4'h3) v[k] = m_force[c[3:0]];
      else v[k] = DO_NATIVE[k];
    end
    return v;
  endfunction
  function automatic logic [15:0] exp_rd(input logic [15:0] a);
    case (a)
      `ADDR_JOG: return 16'(m_jog);
      `ADDR_FORCE: return 16'(m_force);
      `ADDR_INSTAT: return {7'h00, (INPUT_SRC_SEL & 9'(m_sdi)) | (~INPUT_SRC_SEL & EXT_DI)};
      `ADDR_KEYPAD: return {11'h000, KEY_PRESSED};
      `ADDR_OUTSTAT: return {11'h000, exp_do()};
      `ADDR_ADJ: return 16'(m_adj);
      `ADDR_SPD1: return 16'(m_trim[0]);
      `ADDR_SPD2: return 16'(m_trim[1]);
      `ADDR_TRQ1: return 16'(m_trim[2]);
      default: return 16'h0000;
    endcase
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input logic [15:0] a);
    host_link_model_i.read_word(a, rd, ok);
    if (!ok)
    begin
      chk("rvalid", 16'h0001, 16'h0000);
      wrap_up();
    end
    else
      chk($sformatf("read %h", a), exp_rd(a), rd);
  endtask
  task automatic chk_outs();
    @(negedge CLK);
    chk("jog speed", 16'(m_spd), JOG_SPEED);
    chk("jog pos", 16'(m_pos), {15'h0, JOG_POS});
    chk("jog neg", 16'(m_neg), {15'h0, JOG_NEG});
    chk("di final", exp_rd(`ADDR_INSTAT), {7'h00, DI_FINAL});
    chk("do state", {11'h0, exp_do()}, {11'h0, DO_STATE});
    chk("adj run", 16'(m_run), {11'h0, ADJ_RUN});
    chk("trim", 16'(m_trim[0]), SPEED_TRIM_ONE);
    chk("trim", 16'(m_trim[1]), SPEED_TRIM_TWO);
    chk("trim", 16'(m_trim[2]), TORQUE_TRIM_ONE);
    chk("trim", 16'(m_trim[3]), TORQUE_TRIM_TWO);
  endtask
  // write, update the model, then look at the edge where it lands
  task automatic mwrite(input logic [15:0] a, input int d);
    bit st;
    st = 1'b0;
    host_link_model_i.write_word(a, 16'(d));
    if (a == `ADDR_JOG && d <= 5000)
    begin
      m_jog = d;
      if (d == 4998 || d == 4999 || d == 0)
      begin
        m_pos = (d == 4998);
        m_neg = (d == 4999);
      end
      else
        m_spd = d;
    end
    if (a == `ADDR_FORCE) m_force = d;
    if (a == `ADDR_INSTAT) m_sdi = d & 'h1FF;
    if (a == `ADDR_ADJ && PARAM_CTRL == 16'd20 && d <= 6)
    begin
      m_adj = d;
      st = (d != 0);
      m_run = (d == 5) ? 'hF : (d == 6) ? 'h10 : st ? (1 << (d - 1)) : 0;
    end
    if ((a == `ADDR_SPD1 || a == `ADDR_SPD2 || a == `ADDR_TRQ1) && PARAM_CTRL == 16'd22
        && d <= 32767)
    begin
      if (a == `ADDR_SPD1) m_trim[0] = d;
      if (a == `ADDR_SPD2) m_trim[1] = d;
      if (a == `ADDR_TRQ1) m_trim[2] = d;
      if (a == `ADDR_TRQ1) m_trim[3] = d;
    end
    @(negedge CLK);
    chk("adj start", {15'h0, st}, {15'h0, ADJ_START});
  endtask
  // ********************
  // main sequence
  // ********************
  initial
  begin
    RST_N = 1'b0;
    seed = 20359;
    PARAM_CTRL = 16'h0000;
    INPUT_SRC_SEL = 9'h000;
    OUT_FUNC_ASSIGN = 40'h0;
    FORCE_MODE = 1'b0;
    EXT_DI = 9'h0A5;
    DO_NATIVE = 5'h15;
    KEY_PRESSED = 5'h00;
    m_jog = 20;
    m_spd = 20;
    {m_pos, m_neg, m_force, m_sdi, m_adj, m_run} = '0;
    m_trim = '{0, 0, 0, 0};
    repeat (4) @(negedge CLK);
    RST_N = 1'b1;
    foreach (m_trim[k]) rdchk(16'h0416 + 16'(2 * k));
    rdchk(`ADDR_JOG);
    rdchk(`ADDR_FORCE);
    rdchk(16'h040B);
    rdchk(16'h0500);
    chk_outs();
    $display("test reset done");
    mwrite(`ADDR_JOG, 1);
    chk_outs();
    mwrite(`ADDR_JOG, 5000);
    mwrite(`ADDR_JOG, 5001);
    rdchk(`ADDR_JOG);
    mwrite(`ADDR_JOG, 4998);
    chk_outs();
    mwrite(`ADDR_JOG, 4999);
    chk_outs();
    mwrite(`ADDR_JOG, 0);
    chk_outs();
    $display("test jog done");
    for (i = 0; i < 6; i++)
    begin
      EXT_DI = 9'($random(seed));
      INPUT_SRC_SEL = (i == 0) ? 9'h1FF : 9'($random(seed));
      mwrite(`ADDR_INSTAT, $random(seed) & 'hFFFF);
      chk_outs();
      rdchk(`ADDR_INSTAT);
    end
    $display("test inputs done");
    for (i = 0; i < 8; i++)
    begin
      for (n = 0; n < 5; n++)
        OUT_FUNC_ASSIGN[8*n+:8] = ($random(seed) & 1) ? {4'h3, 4'($random(seed))}
                                                      : 8'($random(seed));
      FORCE_MODE = i[0];
      DO_NATIVE = 5'($random(seed));
      KEY_PRESSED = 5'($random(seed));
      mwrite(`ADDR_FORCE, $random(seed) & 'hFFFF);
      chk_outs();
      rdchk(`ADDR_OUTSTAT);
      mwrite(`ADDR_KEYPAD, 'h1F);
      rdchk(`ADDR_KEYPAD);
      rdchk(`ADDR_FORCE);
    end
    $display("test outputs done");
    mwrite(`ADDR_ADJ, 1);
    PARAM_CTRL = 16'd20;
    for (i = 0; i <= 7; i++)
    begin
      mwrite(`ADDR_ADJ, (i + 1) % 8);
      chk_outs();
      rdchk(`ADDR_ADJ);
    end
    $display("test adjust done");
    // trims touched only here, as a protection
    PARAM_CTRL = 16'd22;
    mwrite(`ADDR_SPD1, 32767);
    mwrite(`ADDR_SPD2, 32768);
    mwrite(`ADDR_TRQ1, 'h1234);
    PARAM_CTRL = 16'd20;
    mwrite(`ADDR_SPD2, 5);
    mwrite(`ADDR_JOG, 4998);
    chk_outs();
    PARAM_CTRL = 16'd10;
    repeat (4) @(negedge CLK);
    m_jog = 20;
    m_spd = 20;
    {m_pos, m_neg, m_force, m_sdi, m_adj} = '0;
    chk_outs();
    foreach (m_trim[k]) rdchk(16'h0416 + 16'(2 * k));
    rdchk(`ADDR_ADJ);
    $display("test trims done");
    wrap_up();
  end
endmodule
`default_nettype wire
